// >>> bench/csr_bank_checker.sv
`timescale 1ns/100ps
`default_nettype none
module csr_bank_checker
	import csr_pkg::*;
#(
	parameter int DATA_W = 8
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic warm_reset_i,
	input wire logic [7:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic alu_flags_we_i,
	input wire logic [2:0] alu_flags_i,
	input wire logic sleep_enter_i,
	input wire logic watchdog_clear_i,
	input wire logic watchdog_timeout_i,
	input wire logic [DATA_W-1:0] read_data_o,
	input wire logic [7:0] indirect_pointer_o,
	input wire logic [7:0] program_counter_low_o,
	input wire logic [7:0] cpu_status_o,
	input wire logic [7:0] port_a_pins_o,
	input wire logic [7:0] timer_and_pullup_options_o,
	input wire logic [7:0] port_a_direction_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	// bus and events taken only when enabled and not in warm reset
	wire logic go = clk_en_i && !warm_reset_i;
	wire logic ev = sleep_enter_i || watchdog_clear_i || watchdog_timeout_i;
	unmapped_read_zero_a: assert property (go && rd_i && addr_i == 8'h07 |=> read_data_o == '0)
		else $error("unmapped read not zero");
	port_a_pins_upper_zero_a: assert property (go && wr_i && addr_i == ADDR_PORT_A_PINS |=> port_a_pins_o[7:5] == 3'h0)
		else $error("port a upper bits not zero");
	power_flags_locked_a: assert property (go && wr_i && addr_i[6:0] == 7'h03 && !ev
		|=> cpu_status_o[4:3] == $past(cpu_status_o[4:3]))
		else $error("timeout or power-down flag written");
	alu_flags_win_a: assert property (go && alu_flags_we_i |=> cpu_status_o[2:0] == $past(alu_flags_i))
		else $error("alu flags not loaded");
	status_write_a: assert property (go && wr_i && addr_i[6:0] == 7'h03 && !alu_flags_we_i
		|=> cpu_status_o[2:0] == $past(wdata_i[2:0]))
		else $error("status flags not written");
	warm_loads_a: assert property (clk_en_i && warm_reset_i |=> program_counter_low_o == 8'h00
		&& timer_and_pullup_options_o == 8'hFF && port_a_direction_o == 8'h1F)
		else $error("warm reset values wrong");
	warm_keeps_a: assert property (clk_en_i && warm_reset_i |=> indirect_pointer_o == $past(indirect_pointer_o)
		&& cpu_status_o[2:0] == $past(cpu_status_o[2:0]) && port_a_pins_o[4] == $past(port_a_pins_o[4]))
		else $error("warm reset lost kept bits");
	mirror_write_a: assert property (go && wr_i && addr_i == 8'h84 |=> indirect_pointer_o == $past(wdata_i[7:0]))
		else $error("bank one pointer write missed");
	storage_holds_a: assert property (!(clk_en_i && wr_i) |=> $stable(indirect_pointer_o))
		else $error("pointer changed without write");
endmodule
`default_nettype wire

// >>> bench/csr_bank_tb.sv
`timescale 1ns/100ps
`default_nettype none
module csr_bank_tb;
	import csr_pkg::*;
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic clk_en_i = 1'b1;
	logic warm_reset_i = 1'b0;
	logic [2:0] warm = 3'h0; // timeout, power down, brownout
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic alu_flags_we_i = 1'b0;
	logic [2:0] alu_flags_i = 3'h0;
	logic [2:0] ev = 3'h0; // sleep, clear, timeout
	logic timer_tick_i = 1'b0;
	logic [7:0] read_data_o;
	int bad_count = 0;
	int n_compared = 0;
	logic [7:0] p_a [9] = '{ADDR_STATUS, ADDR_OPTION, ADDR_PORT_A_DIRECTION, ADDR_PORT_B_DIRECTION, ADDR_SERIAL_MEMORY_PIN_INTERFACE, ADDR_PCL, 8'h8A, ADDR_VOLTAGE_REFERENCE_CONTROL,
		ADDR_POWER_RESET_STATUS};
	logic [7:0] p_v [9] = '{8'h18, 8'hFF, 8'h1F, 8'hFF, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] m_a [10] = '{ADDR_PORT_A_PINS, ADDR_PROGRAM_COUNTER_HIGH_LATCH, ADDR_PIR, ADDR_PIE, ADDR_COMPARATOR_CONTROL, ADDR_VOLTAGE_REFERENCE_CONTROL, ADDR_FSR, 8'h07,
		8'h8F, 8'h80};
	logic [7:0] m_v [10] = '{8'h1F, 8'h1F, 8'h40, 8'h40, 8'h0F, 8'hEF, 8'hFF, 8'h00, 8'h00, 8'h00};
	logic [7:0] e_v [3] = '{8'h15, 8'h1D, 8'h0D};
	logic [7:0] w_a [8] = '{ADDR_PCL, ADDR_OPTION, 8'h83, ADDR_FSR, ADDR_PORT_A_PINS, ADDR_POWER_RESET_STATUS, ADDR_TIMER, ADDR_INTERRUPT_CONTROL};
	logic [7:0] w_v [8] = '{8'h00, 8'hFF, 8'h0D, 8'h5A, 8'h10, 8'h01, 8'hFF, 8'h00};
	always #2.5 clock_i = ~clock_i;
	csr_bank dut (.clock_i, .reset_i, .clk_en_i, .warm_reset_i, .warm_timeout_flag_i(warm[2]),
		.warm_power_down_flag_i(warm[1]), .warm_brownout_i(warm[0]), .addr_i, .wdata_i, .wr_i, .rd_i,
		.alu_flags_we_i, .alu_flags_i, .sleep_enter_i(ev[0]), .watchdog_clear_i(ev[1]), .watchdog_timeout_i(ev[2]),
		.pc_low_load_i(1'b0), .pc_low_value_i(8'h00), .timer_tick_i, .interrupt_control_flag_set_i(3'h0),
		.comparator_flag_set_i(1'b0), .comparator_out_i(2'h0), .read_data_o, .indirect_pointer_o(),
		.program_counter_low_o(), .program_counter_high_latch_o(), .cpu_status_o(), .timer_zero_count_o(),
		.port_a_pins_o(), .port_b_pins_o(), .interrupt_control_o(), .peripheral_interrupt_flags_o(),
		.peripheral_interrupt_enables_o(), .comparator_control_o(), .timer_and_pullup_options_o(),
		.port_a_direction_o(), .port_b_direction_o(), .power_reset_status_o(), .serial_memory_pin_interface_o(),
		.voltage_reference_control_o());
	// compare one byte and count it
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one-cycle bus write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	// bus read, data looked at in the one cycle it stands
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 check(read_data_o, exp);
	endtask
	task automatic stop_test();
		$display("compared %0d, wrong %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge clock_i);
		reset_i <= 1'b0;
		for (int i = 0; i < 9; i++) rd(p_a[i], p_v[i]);
		$display("power-up values done");
		for (int i = 0; i < 10; i++) begin
			wr(m_a[i], 8'hFF);
			rd(m_a[i], m_v[i]);
		end
		$display("masks done");
		wr(8'h84, 8'h5A);
		rd(ADDR_FSR, 8'h5A);
		wr(ADDR_PROGRAM_COUNTER_HIGH_LATCH, 8'h13);
		rd(8'h8A, 8'h13);
		wr(8'h8B, 8'h81);
		rd(ADDR_INTERRUPT_CONTROL, 8'h81);
		$display("mirrors done");
		wr(8'h83, 8'h00);
		rd(ADDR_STATUS, 8'h18);
		@(posedge clock_i);
		addr_i <= ADDR_STATUS;
		wdata_i <= 8'h02;
		wr_i <= 1'b1;
		alu_flags_we_i <= 1'b1;
		alu_flags_i <= 3'h5;
		@(posedge clock_i);
		wr_i <= 1'b0;
		alu_flags_we_i <= 1'b0;
		rd(ADDR_STATUS, 8'h1D);
		for (int j = 0; j < 3; j++) begin
			@(posedge clock_i);
			ev <= 3'(1 << j);
			@(posedge clock_i);
			ev <= 3'h0;
			rd(ADDR_STATUS, e_v[j]);
		end
		$display("status done");
		wr(ADDR_TIMER, 8'hFE);
		@(posedge clock_i);
		timer_tick_i <= 1'b1;
		@(posedge clock_i);
		timer_tick_i <= 1'b0;
		repeat (50) @(posedge clock_i);
		rd(ADDR_TIMER, 8'hFF);
		wr(ADDR_PCL, 8'h33);
		wr(ADDR_OPTION, 8'h00);
		@(posedge clock_i);
		warm_reset_i <= 1'b1;
		warm <= 3'h3;
		@(posedge clock_i);
		warm_reset_i <= 1'b0;
		for (int i = 0; i < 8; i++) rd(w_a[i], w_v[i]);
		$display("warm reset done");
		stop_test();
	end
	// watchdog against a hang
	initial begin
		#20000;
		bad_count++;
		$display("wrong value at %0t: run timed out", $time);
		stop_test();
	end
endmodule
bind csr_bank csr_bank_checker #(.DATA_W(DATA_W)) chk (.clock_i, .reset_i, .clk_en_i, .warm_reset_i, .addr_i,
	.wdata_i, .wr_i, .rd_i, .alu_flags_we_i, .alu_flags_i, .sleep_enter_i, .watchdog_clear_i, .watchdog_timeout_i,
	.read_data_o, .indirect_pointer_o, .program_counter_low_o, .cpu_status_o, .port_a_pins_o,
	.timer_and_pullup_options_o, .port_a_direction_o);
`default_nettype wire

// >>> common/csr_pkg.sv
`default_nettype none
package csr_pkg;
	// file addresses as the cpu drives them
	localparam logic [7:0] ADDR_WINDOW = 8'h00;
	localparam logic [7:0] ADDR_TIMER = 8'h01;
	localparam logic [7:0] ADDR_PCL = 8'h02;
	localparam logic [7:0] ADDR_STATUS = 8'h03;
	localparam logic [7:0] ADDR_FSR = 8'h04;
	localparam logic [7:0] ADDR_PORT_A_PINS = 8'h05;
	localparam logic [7:0] ADDR_PORT_B_PINS = 8'h06;
	localparam logic [7:0] ADDR_PROGRAM_COUNTER_HIGH_LATCH = 8'h0A;
	localparam logic [7:0] ADDR_INTERRUPT_CONTROL = 8'h0B;
	localparam logic [7:0] ADDR_PIR = 8'h0C;
	localparam logic [7:0] ADDR_COMPARATOR_CONTROL = 8'h1F;
	localparam logic [7:0] ADDR_OPTION = 8'h81;
	localparam logic [7:0] ADDR_PORT_A_DIRECTION = 8'h85;
	localparam logic [7:0] ADDR_PORT_B_DIRECTION = 8'h86;
	localparam logic [7:0] ADDR_PIE = 8'h8C;
	localparam logic [7:0] ADDR_POWER_RESET_STATUS = 8'h8E;
	localparam logic [7:0] ADDR_SERIAL_MEMORY_PIN_INTERFACE = 8'h90;
	localparam logic [7:0] ADDR_VOLTAGE_REFERENCE_CONTROL = 8'h9F;
	localparam int BANK_BIT = 7;

	// implemented bit masks
	localparam logic [7:0] MASK_PORT_A_PINS = 8'h1F;
	localparam logic [7:0] MASK_PROGRAM_COUNTER_HIGH_LATCH = 8'h1F;
	localparam logic [7:0] MASK_PIR = 8'h40;
	localparam logic [7:0] MASK_PIE = 8'h40;
	localparam logic [7:0] MASK_COMPARATOR_CONTROL = 8'hCF;
	localparam logic [7:0] WMASK_COMPARATOR_CONTROL = 8'h0F;
	localparam logic [7:0] MASK_POWER_RESET_STATUS = 8'h03;
	localparam logic [7:0] MASK_SERIAL_MEMORY_PIN_INTERFACE = 8'h07;
	localparam logic [7:0] MASK_VOLTAGE_REFERENCE_CONTROL = 8'hEF;
	localparam logic [7:0] WMASK_STATUS = 8'hE7;
	localparam logic [7:0] MASK_FLAGS = 8'h07;
	localparam logic [7:0] MASK_INTERRUPT_CONTROL_FLAGS = 8'h07;

	// register field positions
	localparam int ST_TO = 4;
	localparam int ST_PD = 3;
	localparam int CM_C2OUT = 7;
	localparam int CM_C1OUT = 6;
	localparam int PIR_CMIF = 6;
	localparam int POWER_RESET_STATUS_POR = 1;
	localparam int POWER_RESET_STATUS_BOR = 0;

	// power-up reset values, unknown bits taken as zero
	localparam logic [7:0] POR_STATUS = 8'h18;
	localparam logic [7:0] POR_ZERO = 8'h00;
	localparam logic [7:0] POR_ONES = 8'hFF;
	localparam logic [7:0] POR_PORT_A_DIRECTION = 8'h1F;
	localparam logic [7:0] POR_SERIAL_MEMORY_PIN_INTERFACE = 8'h07;

	// warm reset: bits kept across it, bits forced
	localparam logic [7:0] KEEP_STATUS = 8'h07;
	localparam logic [7:0] KEEP_PORT_A_PINS = 8'h10;
	localparam logic [7:0] KEEP_POWER_RESET_STATUS = 8'h02;
endpackage
`default_nettype wire

// >>> hdl/csr_bank.sv
// Notes on behaviour
// - unimplemented locations and bits read zero, ignore writes
// - power-up and warm resets load different values
// - static storage, holds without refresh
// - u keeps, x undefined, q follows cause
// - flag instructions override status flag writes
// - timeout and power-down flags not software writable
`timescale 1ns/100ps
`default_nettype none
module csr_bank
	import csr_pkg::*;
#(
	parameter int DATA_W = 8
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic warm_reset_i,
	input wire logic warm_timeout_flag_i,
	input wire logic warm_power_down_flag_i,
	input wire logic warm_brownout_i,
	input wire logic [7:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic alu_flags_we_i,
	input wire logic [2:0] alu_flags_i,
	input wire logic sleep_enter_i,
	input wire logic watchdog_clear_i,
	input wire logic watchdog_timeout_i,
	input wire logic pc_low_load_i,
	input wire logic [7:0] pc_low_value_i,
	input wire logic timer_tick_i,
	input wire logic [2:0] interrupt_control_flag_set_i,
	input wire logic comparator_flag_set_i,
	input wire logic [1:0] comparator_out_i,
	output logic [DATA_W-1:0] read_data_o,
	output logic [7:0] indirect_pointer_o,
	output logic [7:0] program_counter_low_o,
	output logic [7:0] program_counter_high_latch_o,
	output logic [7:0] cpu_status_o,
	output logic [7:0] timer_zero_count_o,
	output logic [7:0] port_a_pins_o,
	output logic [7:0] port_b_pins_o,
	output logic [7:0] interrupt_control_o,
	output logic [7:0] peripheral_interrupt_flags_o,
	output logic [7:0] peripheral_interrupt_enables_o,
	output logic [7:0] comparator_control_o,
	output logic [7:0] timer_and_pullup_options_o,
	output logic [7:0] port_a_direction_o,
	output logic [7:0] port_b_direction_o,
	output logic [7:0] power_reset_status_o,
	output logic [7:0] serial_memory_pin_interface_o,
	output logic [7:0] voltage_reference_control_o
);

	initial begin
		if (DATA_W != 8) begin
			$error("csr_bank serves an 8-bit data path only");
		end
	end

	// maps a mirrored bank-one address onto its bank-zero twin
	function automatic logic [7:0] fold_addr(input logic [7:0] a);
		logic [7:0] low;
		low = {1'b0, a[6:0]};
		if (a[BANK_BIT] && (low == ADDR_WINDOW || low == ADDR_PCL || low == ADDR_STATUS ||
				low == ADDR_FSR || low == ADDR_PROGRAM_COUNTER_HIGH_LATCH || low == ADDR_INTERRUPT_CONTROL)) begin
			return low;
		end
		return a;
	endfunction

	// register state, flop per register
	logic [7:0] rdata_q, rdata_d;
	logic [7:0] timer_q, timer_d;
	logic [7:0] pcl_q, pcl_d;
	logic [7:0] status_q, status_d;
	logic [7:0] fsr_q, fsr_d;
	logic [7:0] port_a_pins_q, port_a_pins_d;
	logic [7:0] port_b_pins_q, port_b_pins_d;
	logic [7:0] program_counter_high_latch_q, program_counter_high_latch_d;
	logic [7:0] interrupt_control_q, interrupt_control_d;
	logic [7:0] pir_q, pir_d;
	logic [7:0] comparator_control_q, comparator_control_d;
	logic [7:0] option_q, option_d;
	logic [7:0] port_a_direction_q, port_a_direction_d;
	logic [7:0] port_b_direction_q, port_b_direction_d;
	logic [7:0] pie_q, pie_d;
	logic [7:0] power_reset_status_q, power_reset_status_d;
	logic [7:0] serial_memory_pin_interface_q, serial_memory_pin_interface_d;
	logic [7:0] voltage_reference_control_q, voltage_reference_control_d;

	// comparator outputs come from the analog side, three-stage sync
	logic [1:0] cmp_s1_q, cmp_s2_q, cmp_s3_q, cmp_q;
	logic [1:0] cmp_s1_d, cmp_s2_d, cmp_s3_d, cmp_d;

	logic [7:0] addr_f;
	logic wr_hit;
	assign addr_f = fold_addr(addr_i);
	assign wr_hit = wr_i;

	// comparator synchroniser next state
	always_comb begin
		cmp_s1_d = comparator_out_i;
		cmp_s2_d = cmp_s1_q;
		cmp_s3_d = cmp_s2_q;
		cmp_d = cmp_q;
		for (int i = 0; i < 2; i++) begin
			if (cmp_s2_q[i] == cmp_s3_q[i]) begin
				cmp_d[i] = cmp_s3_q[i];
			end
		end
	end

	// read path, answer in the cycle after the strobe
	always_comb begin
		rdata_d = 8'h00;
		if (rd_i) begin
			unique case (fold_addr(addr_i))
				ADDR_TIMER: rdata_d = timer_q;
				ADDR_PCL: rdata_d = pcl_q;
				ADDR_STATUS: rdata_d = status_q;
				ADDR_FSR: rdata_d = fsr_q;
				ADDR_PORT_A_PINS: rdata_d = port_a_pins_q & MASK_PORT_A_PINS;
				ADDR_PORT_B_PINS: rdata_d = port_b_pins_q;
				ADDR_PROGRAM_COUNTER_HIGH_LATCH: rdata_d = program_counter_high_latch_q & MASK_PROGRAM_COUNTER_HIGH_LATCH;
				ADDR_INTERRUPT_CONTROL: rdata_d = interrupt_control_q;
				ADDR_PIR: rdata_d = pir_q & MASK_PIR;
				ADDR_COMPARATOR_CONTROL: rdata_d = comparator_control_q & MASK_COMPARATOR_CONTROL;
				ADDR_OPTION: rdata_d = option_q;
				ADDR_PORT_A_DIRECTION: rdata_d = port_a_direction_q & MASK_PORT_A_PINS;
				ADDR_PORT_B_DIRECTION: rdata_d = port_b_direction_q;
				ADDR_PIE: rdata_d = pie_q & MASK_PIE;
				ADDR_POWER_RESET_STATUS: rdata_d = power_reset_status_q & MASK_POWER_RESET_STATUS;
				ADDR_SERIAL_MEMORY_PIN_INTERFACE: rdata_d = serial_memory_pin_interface_q & MASK_SERIAL_MEMORY_PIN_INTERFACE;
				ADDR_VOLTAGE_REFERENCE_CONTROL: rdata_d = voltage_reference_control_q & MASK_VOLTAGE_REFERENCE_CONTROL;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// register next values: warm reset, bus writes, then hardware events
	always_comb begin
		timer_d = timer_q;
		pcl_d = pcl_q;
		status_d = status_q;
		fsr_d = fsr_q;
		port_a_pins_d = port_a_pins_q;
		port_b_pins_d = port_b_pins_q;
		program_counter_high_latch_d = program_counter_high_latch_q;
		interrupt_control_d = interrupt_control_q;
		pir_d = pir_q;
		comparator_control_d = comparator_control_q;
		option_d = option_q;
		port_a_direction_d = port_a_direction_q;
		port_b_direction_d = port_b_direction_q;
		pie_d = pie_q;
		power_reset_status_d = power_reset_status_q;
		serial_memory_pin_interface_d = serial_memory_pin_interface_q;
		voltage_reference_control_d = voltage_reference_control_q;
		if (warm_reset_i) begin
			// non power-up reset values
			pcl_d = POR_ZERO;
			status_d = status_q & KEEP_STATUS;
			status_d[ST_TO] = warm_timeout_flag_i;
			status_d[ST_PD] = warm_power_down_flag_i;
			port_a_pins_d = port_a_pins_q & KEEP_PORT_A_PINS;
			program_counter_high_latch_d = POR_ZERO;
			interrupt_control_d = POR_ZERO;
			pir_d = POR_ZERO;
			comparator_control_d = POR_ZERO;
			option_d = POR_ONES;
			port_a_direction_d = POR_PORT_A_DIRECTION;
			port_b_direction_d = POR_ONES;
			pie_d = POR_ZERO;
			power_reset_status_d = power_reset_status_q & KEEP_POWER_RESET_STATUS;
			power_reset_status_d[POWER_RESET_STATUS_BOR] = warm_brownout_i;
			voltage_reference_control_d = POR_ZERO;
		end else begin
			if (wr_hit) begin
				unique case (addr_f)
					ADDR_TIMER: timer_d = wdata_i;
					ADDR_PCL: pcl_d = wdata_i;
					ADDR_STATUS: begin
						// timeout and power-down bits stay put
						status_d = (status_q & ~WMASK_STATUS) | (wdata_i & WMASK_STATUS);
					end
					ADDR_FSR: fsr_d = wdata_i;
					ADDR_PORT_A_PINS: port_a_pins_d = wdata_i & MASK_PORT_A_PINS;
					ADDR_PORT_B_PINS: port_b_pins_d = wdata_i;
					ADDR_PROGRAM_COUNTER_HIGH_LATCH: program_counter_high_latch_d = wdata_i & MASK_PROGRAM_COUNTER_HIGH_LATCH;
					ADDR_INTERRUPT_CONTROL: interrupt_control_d = wdata_i;
					ADDR_PIR: pir_d = wdata_i & MASK_PIR;
					ADDR_COMPARATOR_CONTROL: comparator_control_d = (comparator_control_q & ~WMASK_COMPARATOR_CONTROL) | (wdata_i & WMASK_COMPARATOR_CONTROL);
					ADDR_OPTION: option_d = wdata_i;
					ADDR_PORT_A_DIRECTION: port_a_direction_d = wdata_i & MASK_PORT_A_PINS;
					ADDR_PORT_B_DIRECTION: port_b_direction_d = wdata_i;
					ADDR_PIE: pie_d = wdata_i & MASK_PIE;
					ADDR_POWER_RESET_STATUS: power_reset_status_d = wdata_i & MASK_POWER_RESET_STATUS;
					ADDR_SERIAL_MEMORY_PIN_INTERFACE: serial_memory_pin_interface_d = wdata_i & MASK_SERIAL_MEMORY_PIN_INTERFACE;
					ADDR_VOLTAGE_REFERENCE_CONTROL: voltage_reference_control_d = wdata_i & MASK_VOLTAGE_REFERENCE_CONTROL;
					default: ;
				endcase
			end
			// timer counts only when software does not load it
			if (timer_tick_i && !(wr_hit && addr_f == ADDR_TIMER)) begin
				timer_d = 8'(timer_q + 8'h01);
			end
			// cpu program counter update beats a bus write
			if (pc_low_load_i) begin
				pcl_d = pc_low_value_i;
			end
			// alu result flags replace the written ones
			if (alu_flags_we_i) begin
				status_d = (status_d & ~MASK_FLAGS) | {5'h00, alu_flags_i};
			end
			// outside resets, only sleep and watchdog logic move timeout and power-down
			if (watchdog_clear_i) begin
				status_d[ST_TO] = 1'b1;
				status_d[ST_PD] = 1'b1;
			end
			if (sleep_enter_i) begin
				status_d[ST_TO] = 1'b1;
				status_d[ST_PD] = 1'b0;
			end
			if (watchdog_timeout_i) begin
				status_d[ST_TO] = 1'b0;
			end
			// hardware flag set wins over a software clear
			interrupt_control_d = interrupt_control_d | {5'h00, interrupt_control_flag_set_i & MASK_INTERRUPT_CONTROL_FLAGS[2:0]};
			if (comparator_flag_set_i) begin
				pir_d[PIR_CMIF] = 1'b1;
			end
			// comparator outputs are read-only status
			comparator_control_d[CM_C2OUT] = cmp_q[1];
			comparator_control_d[CM_C1OUT] = cmp_q[0];
		end
	end

	// static storage, power-up values on async reset
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_q <= POR_ZERO;
			timer_q <= POR_ZERO;
			pcl_q <= POR_ZERO;
			status_q <= POR_STATUS;
			fsr_q <= POR_ZERO;
			port_a_pins_q <= POR_ZERO;
			port_b_pins_q <= POR_ZERO;
			program_counter_high_latch_q <= POR_ZERO;
			interrupt_control_q <= POR_ZERO;
			pir_q <= POR_ZERO;
			comparator_control_q <= POR_ZERO;
			option_q <= POR_ONES;
			port_a_direction_q <= POR_PORT_A_DIRECTION;
			port_b_direction_q <= POR_ONES;
			pie_q <= POR_ZERO;
			power_reset_status_q <= POR_ZERO;
			serial_memory_pin_interface_q <= POR_SERIAL_MEMORY_PIN_INTERFACE;
			voltage_reference_control_q <= POR_ZERO;
			cmp_s1_q <= 2'h0;
			cmp_s2_q <= 2'h0;
			cmp_s3_q <= 2'h0;
			cmp_q <= 2'h0;
		end else if (clk_en_i) begin
			// contents held indefinitely between accesses
			rdata_q <= rdata_d;
			timer_q <= timer_d;
			pcl_q <= pcl_d;
			status_q <= status_d;
			fsr_q <= fsr_d;
			port_a_pins_q <= port_a_pins_d;
			port_b_pins_q <= port_b_pins_d;
			program_counter_high_latch_q <= program_counter_high_latch_d;
			interrupt_control_q <= interrupt_control_d;
			pir_q <= pir_d;
			comparator_control_q <= comparator_control_d;
			option_q <= option_d;
			port_a_direction_q <= port_a_direction_d;
			port_b_direction_q <= port_b_direction_d;
			pie_q <= pie_d;
			power_reset_status_q <= power_reset_status_d;
			serial_memory_pin_interface_q <= serial_memory_pin_interface_d;
			voltage_reference_control_q <= voltage_reference_control_d;
			cmp_s1_q <= cmp_s1_d;
			cmp_s2_q <= cmp_s2_d;
			cmp_s3_q <= cmp_s3_d;
			cmp_q <= cmp_d;
		end
	end

	// outputs straight from the register flops
	assign read_data_o = rdata_q;
	assign indirect_pointer_o = fsr_q;
	assign program_counter_low_o = pcl_q;
	assign program_counter_high_latch_o = program_counter_high_latch_q;
	assign cpu_status_o = status_q;
	assign timer_zero_count_o = timer_q;
	assign port_a_pins_o = port_a_pins_q;
	assign port_b_pins_o = port_b_pins_q;
	assign interrupt_control_o = interrupt_control_q;
	assign peripheral_interrupt_flags_o = pir_q;
	assign peripheral_interrupt_enables_o = pie_q;
	assign comparator_control_o = comparator_control_q;
	assign timer_and_pullup_options_o = option_q;
	assign port_a_direction_o = port_a_direction_q;
	assign port_b_direction_o = port_b_direction_q;
	assign power_reset_status_o = power_reset_status_q;
	assign serial_memory_pin_interface_o = serial_memory_pin_interface_q;
	assign voltage_reference_control_o = voltage_reference_control_q;

endmodule
`default_nettype wire
